// file: acquisition_threshold_regs.v
// Functional notes
// - offset 24h holds acquisition amplitude bits 0-7
// - join bytes into 15-bit amplitude threshold
// - offset 28h holds phase variance bits 8-15
// - phase variance tested on best antenna
// - acquisition needs phase and amplitude tests
// - offset 2Ch holds phase variance bits 0-7
// - offset 30h holds CCA amplitude bits 8-14
// - compare 15-bit CCA threshold at CCA dwell
// - offset 34h holds CCA amplitude bits 0-7
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "acquisition_threshold_regs.vh"

module acquisition_threshold_regs (
	// clock and reset
	input  wire        clock_in,
	input  wire        sys_rst_in,
	// wishbone slave
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	input  wire        wb_we_in,
	input  wire [7:0]  wb_adr_in,
	input  wire [3:0]  wb_sel_in,
	input  wire [31:0] wb_dat_in,
	output wire [31:0] wb_dat_out,
	output wire        wb_ack_out,
	// transmit and receive enables
	input  wire        transmit_power_enable_in,
	input  wire        receive_power_enable_in,
	// acquisition amplitude dwell
	input  wire        acq_dwell_strobe_in,
	input  wire        dwell_antenna_in,
	input  wire [14:0] acq_amplitude_quality_in,
	// acquisition phase variance on best antenna
	input  wire        phase_strobe_in,
	input  wire        best_antenna_in,
	input  wire [15:0] phase_variance_quality_in,
	// clear channel assessment dwell
	input  wire        cca_dwell_strobe_in,
	input  wire [14:0] cca_amplitude_quality_in,
	// results
	output wire        acq_amp_pass_out,
	output wire        acq_declare_out,
	output wire        cca_amp_pass_out,
	output wire [5:0]  energy_detect_level_out
);

	// amplitude passes when measured quality reaches threshold
	// shared by the acquisition and cca dwells
	// lower threshold passes more dwells
	function amp_pass;
		input [14:0] quality;
		input [14:0] threshold;
		begin
			amp_pass = (quality >= threshold);
		end
	endfunction

	// phase variance passes when variance stays at or below threshold
	// higher threshold passes noisier carriers
	function phase_pass;
		input [15:0] variance;
		input [15:0] threshold;
		begin
			phase_pass = (variance <= threshold);
		end
	endfunction

	// write data for one byte lane
	// a write with lane 0 off keeps the old byte
	// upper lanes carry nothing in this bank
	function [7:0] lane_byte;
		input [7:0] old_value;
		input       sel0;
		input [7:0] data;
		begin
			if (sel0) begin
				lane_byte = data;
			end else begin
				lane_byte = old_value;
			end
		end
	endfunction

	// threshold registers
	// bit 7 of the amplitude high bytes is stored but unused
	reg  [7:0]  acq_amplitude_threshold_high_reg;
	reg  [7:0]  acq_amplitude_threshold_low_reg;
	reg  [7:0]  acq_phase_threshold_high_reg;
	reg  [7:0]  acq_phase_threshold_low_reg;
	reg  [7:0]  cca_amplitude_threshold_high_reg;
	reg  [7:0]  cca_amplitude_threshold_low_reg;
	reg  [7:0]  energy_detect_threshold_reg;

	// bus state
	reg         ack_reg;
	reg  [31:0] rd_data_reg;
	reg  [31:0] rd_data_next;

	// comparison state
	// index 0 is antenna a, index 1 antenna b
	reg  [1:0]  amp_pass_ant_reg;
	reg         phase_pass_reg;
	reg         acq_declare_reg;
	reg         acq_declared_reg;
	reg         cca_pass_reg;

	// assembled thresholds
	wire [14:0] acq_amp_threshold;
	wire [15:0] acq_phase_threshold;
	wire [14:0] cca_amp_threshold;

	// bus qualifiers and live comparison results
	wire        bus_req;
	wire        bus_write;
	wire        amp_ok_now;
	wire        phase_ok_now;
	wire        best_amp_ok;
	wire        cca_ok_now;

	// thresholds are joined live from the bytes
	// bytes may be written in any order
	// a half-written pair is used as it stands
	// join amplitude bytes
	assign acq_amp_threshold = {acq_amplitude_threshold_high_reg[`AMP_HIGH_BITS-1:0],
		acq_amplitude_threshold_low_reg};
	assign acq_phase_threshold = {acq_phase_threshold_high_reg, acq_phase_threshold_low_reg};
	assign cca_amp_threshold = {cca_amplitude_threshold_high_reg[`AMP_HIGH_BITS-1:0],
		cca_amplitude_threshold_low_reg};

	// one access per request, ack held one cycle
	// blocking on ack_reg keeps a held request from a second take
	// a new request right after the ack cycle is taken with no idle cycle between
	assign bus_req   = wb_cyc_in & wb_stb_in & ~ack_reg;
	assign bus_write = bus_req & wb_we_in;

	// register writes, low byte lane only
	// unmapped writes are acked and dropped
	// writes are not blocked while enables are high
	always @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			acq_amplitude_threshold_high_reg <= `ACQ_AMP_HIGH_RST;
			acq_amplitude_threshold_low_reg  <= `ACQ_AMP_LOW_RST;
			acq_phase_threshold_high_reg     <= `ACQ_PHASE_HIGH_RST;
			acq_phase_threshold_low_reg      <= `ACQ_PHASE_LOW_RST;
			cca_amplitude_threshold_high_reg <= `CCA_AMP_HIGH_RST;
			cca_amplitude_threshold_low_reg  <= `CCA_AMP_LOW_RST;
			energy_detect_threshold_reg      <= `ENERGY_THRESH_RST;
		end else if (bus_write) begin
			if (wb_adr_in == `ACQ_AMP_HIGH_ADDR) begin
				acq_amplitude_threshold_high_reg <= lane_byte(
					acq_amplitude_threshold_high_reg, wb_sel_in[0], wb_dat_in[7:0]);
			end else if (wb_adr_in == `ACQ_AMP_LOW_ADDR) begin
				acq_amplitude_threshold_low_reg <= lane_byte(
					acq_amplitude_threshold_low_reg, wb_sel_in[0], wb_dat_in[7:0]);
			end else if (wb_adr_in == `ACQ_PHASE_HIGH_ADDR) begin
				acq_phase_threshold_high_reg <= lane_byte(
					acq_phase_threshold_high_reg, wb_sel_in[0], wb_dat_in[7:0]);
			end else if (wb_adr_in == `ACQ_PHASE_LOW_ADDR) begin
				acq_phase_threshold_low_reg <= lane_byte(
					acq_phase_threshold_low_reg, wb_sel_in[0], wb_dat_in[7:0]);
			end else if (wb_adr_in == `CCA_AMP_HIGH_ADDR) begin
				cca_amplitude_threshold_high_reg <= lane_byte(
					cca_amplitude_threshold_high_reg, wb_sel_in[0], wb_dat_in[7:0]);
			end else if (wb_adr_in == `CCA_AMP_LOW_ADDR) begin
				cca_amplitude_threshold_low_reg <= lane_byte(
					cca_amplitude_threshold_low_reg, wb_sel_in[0], wb_dat_in[7:0]);
			end else if (wb_adr_in == `ENERGY_THRESH_ADDR) begin
				energy_detect_threshold_reg <= lane_byte(
					energy_detect_threshold_reg, wb_sel_in[0], wb_dat_in[7:0]);
			end
		end
	end

	// read mux, unmapped reads as zero
	// status word is read-only, writes to it are dropped
	// enables are shown as sampled, not stored
	always @* begin
		rd_data_next = 32'h0000_0000;
		if (wb_adr_in == `ACQ_AMP_HIGH_ADDR) begin
			rd_data_next[7:0] = acq_amplitude_threshold_high_reg;
		end else if (wb_adr_in == `ACQ_AMP_LOW_ADDR) begin
			rd_data_next[7:0] = acq_amplitude_threshold_low_reg;
		end else if (wb_adr_in == `ACQ_PHASE_HIGH_ADDR) begin
			rd_data_next[7:0] = acq_phase_threshold_high_reg;
		end else if (wb_adr_in == `ACQ_PHASE_LOW_ADDR) begin
			rd_data_next[7:0] = acq_phase_threshold_low_reg;
		end else if (wb_adr_in == `CCA_AMP_HIGH_ADDR) begin
			rd_data_next[7:0] = cca_amplitude_threshold_high_reg;
		end else if (wb_adr_in == `CCA_AMP_LOW_ADDR) begin
			rd_data_next[7:0] = cca_amplitude_threshold_low_reg;
		end else if (wb_adr_in == `ENERGY_THRESH_ADDR) begin
			rd_data_next[7:0] = energy_detect_threshold_reg;
		end else if (wb_adr_in == `STATUS_ADDR) begin
			rd_data_next[`STAT_ACQ_AMP_A]    = amp_pass_ant_reg[0];
			rd_data_next[`STAT_ACQ_AMP_B]    = amp_pass_ant_reg[1];
			rd_data_next[`STAT_PHASE_PASS]   = phase_pass_reg;
			rd_data_next[`STAT_ACQ_DECLARED] = acq_declared_reg;
			rd_data_next[`STAT_CCA_PASS]     = cca_pass_reg;
			rd_data_next[`STAT_TX_ENABLE]    = transmit_power_enable_in;
			rd_data_next[`STAT_RX_ENABLE]    = receive_power_enable_in;
		end
	end

	// read data is loaded only when a read is taken
	// so it holds between reads for a slow master
	// readback of written values
	always @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ack_reg     <= 1'b0;
			rd_data_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req;
			if (bus_req & ~wb_we_in) begin
				rd_data_reg <= rd_data_next;
			end
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_dat_out = rd_data_reg;

	assign amp_ok_now   = amp_pass(acq_amplitude_quality_in, acq_amp_threshold);
	assign phase_ok_now = phase_pass(phase_variance_quality_in, acq_phase_threshold);
	assign cca_ok_now   = amp_pass(cca_amplitude_quality_in, cca_amp_threshold);
	assign best_amp_ok  = best_antenna_in ? amp_pass_ant_reg[1] : amp_pass_ant_reg[0];

	// acquisition dwell results per antenna
	// receiver off wipes stale dwell results
	// each dwell overwrites only its own antenna
	always @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			amp_pass_ant_reg <= 2'b00;
		end else if (~receive_power_enable_in) begin
			amp_pass_ant_reg <= 2'b00;
		end else if (acq_dwell_strobe_in) begin
			if (dwell_antenna_in) begin
				amp_pass_ant_reg[1] <= amp_ok_now;
			end else begin
				amp_pass_ant_reg[0] <= amp_ok_now;
			end
		end
	end

	// phase test and acquisition decision
	// the amplitude bit used is that of the best antenna
	// declared flag is sticky until receiver off
	// receiver off wins over a strobe in the same cycle
	always @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			phase_pass_reg   <= 1'b0;
			acq_declare_reg  <= 1'b0;
			acq_declared_reg <= 1'b0;
		end else begin
			acq_declare_reg <= 1'b0;
			if (~receive_power_enable_in) begin
				phase_pass_reg   <= 1'b0;
				acq_declared_reg <= 1'b0;
			end else if (phase_strobe_in) begin
				phase_pass_reg <= phase_ok_now;
				if (phase_ok_now & best_amp_ok) begin
					acq_declare_reg  <= 1'b1;
					acq_declared_reg <= 1'b1;
				end
			end
		end
	end

	// clear channel assessment dwell result
	// kept across receiver off, cca runs before receive
	always @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cca_pass_reg <= 1'b0;
		end else if (cca_dwell_strobe_in) begin
			cca_pass_reg <= cca_ok_now;
		end
	end

	// result outputs
	// amplitude pass follows the best antenna select directly
	// energy level drops the two unused top bits
	assign acq_amp_pass_out        = best_amp_ok;
	assign acq_declare_out         = acq_declare_reg;
	assign cca_amp_pass_out        = cca_pass_reg;
	assign energy_detect_level_out = energy_detect_threshold_reg[`ENERGY_LEVEL_BITS-1:0];

endmodule
`default_nettype wire

// file: acquisition_threshold_regs.vh
`ifndef ACQUISITION_THRESHOLD_REGS_VH
`define ACQUISITION_THRESHOLD_REGS_VH

// byte addresses of the threshold and status registers
`define ACQ_AMP_HIGH_ADDR   8'h20
`define ACQ_AMP_LOW_ADDR    8'h24
`define ACQ_PHASE_HIGH_ADDR 8'h28
`define ACQ_PHASE_LOW_ADDR  8'h2c
`define CCA_AMP_HIGH_ADDR   8'h30
`define CCA_AMP_LOW_ADDR    8'h34
`define ENERGY_THRESH_ADDR  8'h38
`define STATUS_ADDR         8'h40

// reset values of the threshold registers
`define ACQ_AMP_HIGH_RST    8'h00
`define ACQ_AMP_LOW_RST     8'h00
`define ACQ_PHASE_HIGH_RST  8'h00
`define ACQ_PHASE_LOW_RST   8'h00
`define CCA_AMP_HIGH_RST    8'h00
`define CCA_AMP_LOW_RST     8'h00
`define ENERGY_THRESH_RST   8'h3f

// field layout
`define AMP_HIGH_BITS       7
`define ENERGY_LEVEL_BITS   6
`define STAT_ACQ_AMP_A      0
`define STAT_ACQ_AMP_B      1
`define STAT_PHASE_PASS     2
`define STAT_ACQ_DECLARED   3
`define STAT_CCA_PASS       4
`define STAT_TX_ENABLE      5
`define STAT_RX_ENABLE      6

`endif

// file: acquisition_threshold_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module acquisition_threshold_regs_chk (
	// bus and measurement ports watched
	input wire logic        clock_in,
	input wire logic        sys_rst_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic        wb_ack_out,
	input wire logic        phase_strobe_in,
	input wire logic        cca_dwell_strobe_in,
	input wire logic        acq_declare_out,
	input wire logic        cca_amp_pass_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	a_ack_after_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing after request");
	a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	a_ack_has_req: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
		else $error("ack without request");
	a_no_idle_ack: assert property (!wb_cyc_in |=> !wb_ack_out)
		else $error("ack while bus idle");
	a_read_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_read_data_holds: assert property (
		!(wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out) |=> $stable(wb_dat_out))
		else $error("read data changed without read");
	a_declare_cause: assert property (acq_declare_out |-> $past(phase_strobe_in))
		else $error("declare without phase strobe");
	a_cca_only_dwell: assert property (!cca_dwell_strobe_in |=> $stable(cca_amp_pass_out))
		else $error("cca result moved without dwell");
endmodule
bind acquisition_threshold_regs acquisition_threshold_regs_chk u_chk (
	.clock_in(clock_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
	.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out),
	.wb_ack_out(wb_ack_out), .phase_strobe_in(phase_strobe_in),
	.cca_dwell_strobe_in(cca_dwell_strobe_in), .acq_declare_out(acq_declare_out),
	.cca_amp_pass_out(cca_amp_pass_out));
`default_nettype wire

// file: host_wb_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_wb_model (
	// clock and slave answer
	input wire logic        clock_in,
	input wire logic        ack_in,
	input wire logic [31:0] rdat_in,
	// wishbone request
	output logic            cyc_out,
	output logic            stb_out,
	output logic            we_out,
	output logic [7:0]      adr_out,
	output logic [3:0]      sel_out,
	output logic [31:0]     dat_out
);
	// bus idle at time zero
	initial begin
		cyc_out = 1'b0;
		stb_out = 1'b0;
		we_out = 1'b0;
		adr_out = 8'h00;
		sel_out = 4'h0;
		dat_out = 32'h0;
	end
	// one classic cycle, called only while enables are low for writes
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		cyc_out <= 1'b1;
		stb_out <= 1'b1;
		we_out <= w;
		adr_out <= a;
		sel_out <= 4'h1;
		dat_out <= {24'h0, d};
		@(posedge clock_in);
		while (ack_in !== 1'b1) @(posedge clock_in);
		q = rdat_in;
		cyc_out <= 1'b0;
		stb_out <= 1'b0;
		@(posedge clock_in);
	endtask
endmodule
`default_nettype wire

// file: acquisition_threshold_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module acquisition_threshold_regs_tb_top;
	logic clock_in = 1'b0, sys_rst_in = 1'b1, tx_en = 1'b0, rx_en = 1'b0;
	logic acq_stb = 1'b0, ant = 1'b0, ph_stb = 1'b0, best = 1'b0, cca_stb = 1'b0;
	logic [14:0] acq_q = 15'h0, cca_q = 15'h0;
	logic [15:0] ph_q = 16'h0;
	logic [31:0] q;
	wire cyc, stb, we, ack, amp_pass, declare, cca_pass;
	wire [7:0] adr;
	wire [3:0] sel;
	wire [31:0] wdat, rdat;
	wire [5:0] energy_lvl;
	int fails = 0, cmp_count = 0;
	logic [7:0] ra[6] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34};
	logic [7:0] rv[6] = '{8'h81, 8'ha5, 8'h5a, 8'hc3, 8'h3c, 8'h96};
	logic [7:0] tv[6] = '{8'h00, 8'h10, 8'h01, 8'h00, 8'h01, 8'h00};
	always #5 clock_in = ~clock_in;
	host_wb_model u_host (.clock_in(clock_in), .ack_in(ack), .rdat_in(rdat), .cyc_out(cyc),
		.stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));
	acquisition_threshold_regs u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .transmit_power_enable_in(tx_en),
		.receive_power_enable_in(rx_en), .acq_dwell_strobe_in(acq_stb), .dwell_antenna_in(ant),
		.acq_amplitude_quality_in(acq_q), .phase_strobe_in(ph_stb), .best_antenna_in(best),
		.phase_variance_quality_in(ph_q), .cca_dwell_strobe_in(cca_stb),
		.cca_amplitude_quality_in(cca_q), .acq_amp_pass_out(amp_pass),
		.acq_declare_out(declare), .cca_amp_pass_out(cca_pass),
		.energy_detect_level_out(energy_lvl));
	task chk(string n, logic [31:0] e, logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task rd(string n, logic [7:0] a, logic [31:0] e);
		u_host.xfer(1'b0, a, 8'h00, q);
		chk(n, e, q);
	endtask
	// one measurement strobe, outputs looked at just after it lands
	task pulse(int k);
		@(posedge clock_in);
		acq_stb <= (k == 0);
		ph_stb <= (k == 1);
		cca_stb <= (k == 2);
		@(posedge clock_in);
		acq_stb <= 1'b0;
		ph_stb <= 1'b0;
		cca_stb <= 1'b0;
		#1;
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// watchdog
	initial begin
		#20000;
		fails++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		@(posedge clock_in);
		rd("energy_reset", 8'h38, 32'h3f);
		chk("energy_level", 32'h3f, {26'h0, energy_lvl});
		u_host.xfer(1'b1, 8'h38, 8'hd5, q);
		rd("energy_byte", 8'h38, 32'hd5);
		chk("energy_level_wr", 32'h15, {26'h0, energy_lvl});
		for (int i = 0; i < 6; i++) u_host.xfer(1'b1, ra[i], rv[i], q);
		for (int i = 0; i < 6; i++) rd("thr_byte", ra[i], {24'h0, rv[i]});
		rd("unmapped", 8'h44, 32'h0);
		$display("register test done");
		for (int i = 0; i < 6; i++) u_host.xfer(1'b1, ra[i], tv[i], q);
		rx_en <= 1'b1;
		ant <= 1'b1;
		best <= 1'b1;
		acq_q <= 15'h000f;
		pulse(0);
		chk("amp_below", 0, amp_pass);
		acq_q <= 15'h0010;
		pulse(0);
		chk("amp_at", 1, amp_pass);
		ph_q <= 16'h0101;
		pulse(1);
		chk("phase_above", 0, declare);
		ph_q <= 16'h0100;
		pulse(1);
		chk("phase_at", 1, declare);
		best <= 1'b0;
		pulse(1);
		chk("other_antenna", 0, declare);
		cca_q <= 15'h00ff;
		pulse(2);
		chk("cca_below", 0, cca_pass);
		cca_q <= 15'h0100;
		pulse(2);
		chk("cca_at", 1, cca_pass);
		tx_en <= 1'b1;
		rd("status_on", 8'h40, 32'h7e);
		rx_en <= 1'b0;
		@(posedge clock_in);
		rd("status_off", 8'h40, 32'h30);
		chk("declare_idle", 0, declare);
		$display("measurement test done");
		report_and_stop;
	end
endmodule
`default_nettype wire
